/* File: inc/soc_pkg.sv */
// package: register map, field layout, reset values and types of the system options block
//
// Contract
// - options register always readable; bits 4:0 read zero.
// - only first options write after reset is taken; later writes ignored.
// - options bit 7 enables watchdog, reset 1; timeout then forces reset.
// - options bit 6 selects long watchdog timeout, reset 1; 0 short.
// - options bit 5 permits stop, reset 0; stop while denied forces reset.
// - clock-output bit 4 enables the divided clock on its port pin.
// - nonzero divide field in bits 2:0 gives bus clock over twice field.
// - enabled with zero divide field holds the pin low.
// - part number registers are read-only identification for a debug host.
// - 12-bit part number: bits 11:8 in high 3:0, bits 7:0 low.
// - high register bits 7:4 reserved; writes have no effect.
package soc_pkg;

  localparam logic [31:0] SOC_OFS_OPTIONS = 32'h0000_0000;
  localparam logic [31:0] SOC_OFS_CLKOUT = 32'h0000_0004;
  localparam logic [31:0] SOC_OFS_PART_HIGH = 32'h0000_0008;
  localparam logic [31:0] SOC_OFS_PART_LOW = 32'h0000_000C;
  localparam int SOC_ADDR_BITS = 4;

  localparam int SOC_OPT_WDOG_EN_BIT = 7;
  localparam int SOC_OPT_WDOG_LONG_BIT = 6;
  localparam int SOC_OPT_STOP_BIT = 5;
  localparam logic [7:0] SOC_OPT_RESET = 8'hC0;
  localparam logic [7:0] SOC_OPT_MASK = 8'hE0;

  localparam int SOC_CLK_EN_BIT = 4;
  localparam int SOC_DIV_W = 3;
  localparam logic [7:0] SOC_CLK_RESET = 8'h00;
  localparam logic [7:0] SOC_CLK_MASK = 8'h17;

  localparam int SOC_PART_HI_LSB = 8;
  localparam logic [3:0] SOC_PART_RSVD = 4'h0;

  localparam logic [1:0] SOC_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] SOC_HSIZE_WORD = 3'h2;

  typedef struct packed {
    logic watchdog_enable;
    logic watchdog_long_timeout;
    logic stop_mode_permit;
  } soc_options_type;

  typedef struct packed {
    logic clock_out_pin_enable;
    logic [SOC_DIV_W-1:0] clock_out_divider_select;
  } soc_clkout_type;

endpackage : soc_pkg

/* File: core/soc_clkout_gen.sv */
// module: divided bus clock generator for the clock output pin
`timescale 1ns/1ps
`default_nettype none
module soc_clkout_gen
  import soc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire soc_pkg::soc_clkout_type cfg,
  output logic pin_q,
  output logic pin_oe_n_q
);
  logic [SOC_DIV_W-1:0] cnt_q, cnt_d;
  logic pin_d, oe_n_d;

  always_comb begin
    cnt_d = cnt_q;
    pin_d = 1'b0;
    oe_n_d = ~cfg.clock_out_pin_enable;
    if (!cfg.clock_out_pin_enable || cfg.clock_out_divider_select == '0) begin
      cnt_d = '0;
    end else if (cnt_q >= cfg.clock_out_divider_select - 3'h1) begin
      cnt_d = '0;
      pin_d = ~pin_q;
    end else begin
      cnt_d = cnt_q + 3'h1;
      pin_d = pin_q;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= '0;
      pin_q <= 1'b0;
      pin_oe_n_q <= 1'b1;
    end else begin
      cnt_q <= cnt_d;
      pin_q <= pin_d;
      pin_oe_n_q <= oe_n_d;
    end
  end
endmodule : soc_clkout_gen
`default_nettype wire

/* File: core/soc_sysopt.sv */
// module: system options, clock output control and part number registers on AHB-Lite
//
// The implementer's own choices: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
module soc_sysopt #(
  parameter logic [11:0] PART_NUMBER = 12'hA5C // arbitrary value
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic watchdog_timeout,
  input wire logic stop_executed,
  output logic watchdog_enable,
  output logic watchdog_long_timeout,
  output logic stop_mode_permit,
  output logic watchdog_reset_req,
  output logic illegal_opcode_reset_req,
  output logic clock_out_port_pin,
  output logic clock_out_port_pin_oe_n
);
  import soc_pkg::*;

  // ------------------------------------------------------------
  // address phase capture
  // ------------------------------------------------------------
  logic wr_pend_q, wr_pend_d;
  logic rd_pend_d;
  logic [SOC_ADDR_BITS-1:0] addr_q, addr_d;
  logic take;

  assign take = hsel && hready && htrans == SOC_HTRANS_NONSEQ;

  always_comb begin
    // writes decode the same address window as reads: upper bits must be zero
    wr_pend_d = take && hwrite && haddr[31:SOC_ADDR_BITS] == '0;
    rd_pend_d = take && !hwrite;
    addr_d = take ? haddr[SOC_ADDR_BITS-1:0] : addr_q;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      addr_q <= '0;
    end else begin
      wr_pend_q <= wr_pend_d;
      addr_q <= addr_d;
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  soc_options_type opt_q, opt_d;
  logic opt_locked_q, opt_locked_d;
  soc_clkout_type clk_q, clk_d;
  logic [31:0] rdata_d;
  logic [7:0] opt_rd, clk_rd;

  always_comb begin
    opt_d = opt_q;
    opt_locked_d = opt_locked_q;
    clk_d = clk_q;
    if (wr_pend_q && addr_q == SOC_OFS_OPTIONS[SOC_ADDR_BITS-1:0] && !opt_locked_q) begin
      opt_d.watchdog_enable = hwdata[SOC_OPT_WDOG_EN_BIT];
      opt_d.watchdog_long_timeout = hwdata[SOC_OPT_WDOG_LONG_BIT];
      opt_d.stop_mode_permit = hwdata[SOC_OPT_STOP_BIT];
      opt_locked_d = 1'b1;
    end
    if (wr_pend_q && addr_q == SOC_OFS_CLKOUT[SOC_ADDR_BITS-1:0]) begin
      clk_d.clock_out_pin_enable = hwdata[SOC_CLK_EN_BIT];
      clk_d.clock_out_divider_select = hwdata[SOC_DIV_W-1:0];
    end
  end

  always_comb begin
    opt_rd = {opt_q, 5'h00} & SOC_OPT_MASK;
    clk_rd = {3'h0, clk_q.clock_out_pin_enable, 1'b0, clk_q.clock_out_divider_select} & SOC_CLK_MASK;
    rdata_d = 32'h0000_0000;
    if (rd_pend_d) begin
      unique case (haddr[SOC_ADDR_BITS-1:0])
        SOC_OFS_OPTIONS[SOC_ADDR_BITS-1:0]: rdata_d = {24'h000000, opt_rd};
        SOC_OFS_CLKOUT[SOC_ADDR_BITS-1:0]: rdata_d = {24'h000000, clk_rd};
        SOC_OFS_PART_HIGH[SOC_ADDR_BITS-1:0]: begin
          rdata_d = {24'h000000, SOC_PART_RSVD, PART_NUMBER[11:SOC_PART_HI_LSB]};
        end
        SOC_OFS_PART_LOW[SOC_ADDR_BITS-1:0]: begin
          rdata_d = {24'h000000, PART_NUMBER[SOC_PART_HI_LSB-1:0]};
        end
        default: rdata_d = 32'h0000_0000;
      endcase
      if (haddr[31:SOC_ADDR_BITS] != '0) begin
        rdata_d = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      opt_q <= soc_options_type'(SOC_OPT_RESET[7:5]);
      opt_locked_q <= 1'b0;
      clk_q <= soc_clkout_type'(4'h0);
      hrdata <= 32'h0000_0000;
    end else begin
      opt_q <= opt_d;
      opt_locked_q <= opt_locked_d;
      clk_q <= clk_d;
      hrdata <= rdata_d;
    end
  end

  // ------------------------------------------------------------
  // outputs to watchdog and reset logic
  // ------------------------------------------------------------
  logic wd_rst_d, ilop_rst_d;

  always_comb begin
    wd_rst_d = opt_q.watchdog_enable && watchdog_timeout;
    ilop_rst_d = !opt_q.stop_mode_permit && stop_executed;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      watchdog_enable <= SOC_OPT_RESET[SOC_OPT_WDOG_EN_BIT];
      watchdog_long_timeout <= SOC_OPT_RESET[SOC_OPT_WDOG_LONG_BIT];
      stop_mode_permit <= SOC_OPT_RESET[SOC_OPT_STOP_BIT];
      watchdog_reset_req <= 1'b0;
      illegal_opcode_reset_req <= 1'b0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      watchdog_enable <= opt_q.watchdog_enable;
      watchdog_long_timeout <= opt_q.watchdog_long_timeout;
      stop_mode_permit <= opt_q.stop_mode_permit;
      watchdog_reset_req <= wd_rst_d;
      illegal_opcode_reset_req <= ilop_rst_d;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // clock output
  // ------------------------------------------------------------
  soc_clkout_gen u_clkout (
    .hclk(hclk),
    .hresetn(hresetn),
    .cfg(clk_q),
    .pin_q(clock_out_port_pin),
    .pin_oe_n_q(clock_out_port_pin_oe_n)
  );

  logic [2:0] unused_ok;
  assign unused_ok = hsize;
endmodule : soc_sysopt
`default_nettype wire

/* File: testbench/soc_sysopt_props.sv */
// checker: port properties of the system options block
`timescale 1ns/1ps
`default_nettype none
module soc_sysopt_props (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic watchdog_timeout,
  input wire logic stop_executed,
  input wire logic watchdog_enable,
  input wire logic watchdog_long_timeout,
  input wire logic stop_mode_permit,
  input wire logic watchdog_reset_req,
  input wire logic illegal_opcode_reset_req,
  input wire logic clock_out_port_pin,
  input wire logic clock_out_port_pin_oe_n
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // the option outputs trail the register by one cycle, as do the reset requests
  sequence s_wdog_armed;
    watchdog_timeout ##1 watchdog_enable;
  endsequence
  sequence s_wdog_off;
    watchdog_timeout ##1 !watchdog_enable;
  endsequence
  sequence s_stop_denied;
    stop_executed ##1 !stop_mode_permit;
  endsequence
  sequence s_stop_allowed;
    stop_executed ##1 stop_mode_permit;
  endsequence
  AST_WDOG_REQ: assert property (s_wdog_armed |-> watchdog_reset_req)
    else $error("watchdog reset missing");
  AST_WDOG_OFF: assert property (s_wdog_off |-> !watchdog_reset_req)
    else $error("watchdog reset while disabled");
  AST_STOP_OK: assert property (s_stop_allowed |-> !illegal_opcode_reset_req)
    else $error("stop reset while permitted");
  AST_WDOG_QUIET: assert property (!watchdog_timeout |=> !watchdog_reset_req)
    else $error("stray watchdog reset");
  AST_STOP_REQ: assert property (s_stop_denied |-> illegal_opcode_reset_req)
    else $error("stop reset missing");
  AST_STOP_QUIET: assert property (!stop_executed |=> !illegal_opcode_reset_req)
    else $error("stray stop reset");
  AST_RST_VAL: assert property ($rose(hresetn) |-> watchdog_enable && watchdog_long_timeout
    && !stop_mode_permit && clock_out_port_pin_oe_n && !clock_out_port_pin) else $error("bad reset value");
  AST_LOCK: assert property ($changed(watchdog_enable) |=> $stable(watchdog_enable)[*8])
    else $error("option changed twice");
  AST_PIN_OFF: assert property (clock_out_port_pin_oe_n |-> !clock_out_port_pin)
    else $error("pin active while off");
  AST_BUS_OK: assert property (hreadyout && !hresp)
    else $error("bus not ready");
endmodule : soc_sysopt_props
bind soc_sysopt soc_sysopt_props u_props (.hclk, .hresetn, .hreadyout, .hresp, .watchdog_timeout, .stop_executed,
  .watchdog_enable, .watchdog_long_timeout, .stop_mode_permit, .watchdog_reset_req, .illegal_opcode_reset_req,
  .clock_out_port_pin, .clock_out_port_pin_oe_n);
`default_nettype wire

/* File: testbench/system_options_clkout_partnum_test.sv */
// testbench: register, option lock and clock output checks
`timescale 1ns/1ps
`default_nettype none
module system_options_clkout_partnum_test;
  import soc_pkg::*;
  localparam logic [11:0] PN = 12'h3B7; // arbitrary value
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, watchdog_timeout, stop_executed, p;
  logic rd_q = 1'b0;
  logic [31:0] rv;
  logic watchdog_enable, watchdog_long_timeout, stop_mode_permit, watchdog_reset_req, illegal_opcode_reset_req;
  logic clock_out_port_pin, clock_out_port_pin_oe_n;
  logic [31:0] haddr, hwdata, hrdata, c, v;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] exp_q[$];
  wire logic hready;
  int err_total = 0;
  int num_checks = 0;
  bit [31:0] rs = 32'h7A21;
  assign hready = hreadyout;
  soc_sysopt #(.PART_NUMBER(PN)) u_soc_sysopt (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .watchdog_timeout, .stop_executed, .watchdog_enable, .watchdog_long_timeout,
    .stop_mode_permit, .watchdog_reset_req, .illegal_opcode_reset_req, .clock_out_port_pin, .clock_out_port_pin_oe_n);
  function automatic bit [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction : xs
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic end_of_test();
    $display("errors %0d checks %0d", err_total, num_checks);
    if (err_total == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d, input logic [31:0] e);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    if (!w) exp_q.push_back(e);
    do @(posedge hclk); while (hready !== 1'b1);
  endtask : bus
  task automatic rst_defaults();
    hresetn <= 1'b0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(32'h0, 1'b0, 32'h0, 32'hC0);
    bus(32'h4, 1'b0, 32'h0, 32'h0);
    bus(32'h10, 1'b0, 32'h0, 32'h0);
  endtask : rst_defaults
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  initial begin
    repeat (3000) @(posedge hclk);
    err_total++;
    end_of_test();
  end
  // read watcher, random watchdog and stop events
  always @(posedge hclk) begin
    if (rd_q) chk(hrdata, exp_q.pop_front());
    rd_q = hsel && hready && htrans == 2'h2 && !hwrite;
    rv = xs();
    watchdog_timeout <= rv[0];
    stop_executed <= rv[1];
  end
  initial begin
    {hresetn, hsel, hwrite} = 3'h0;
    {haddr, hwdata, htrans} = 66'h0;
    hsize = 3'h2;
    rst_defaults();
    v = xs();
    bus(32'h8, 1'b1, v, 32'h0);
    bus(32'hC, 1'b1, v, 32'h0);
    bus(32'h8, 1'b0, 32'h0, {28'h0, PN[11:8]});
    bus(32'hC, 1'b0, 32'h0, {24'h0, PN[7:0]});
    bus(32'h10, 1'b1, 32'h0, 32'h0);
    bus(32'h0, 1'b1, 32'h3C, 32'h0);
    bus(32'h0, 1'b0, 32'h0, 32'h20);
    chk({29'h0, watchdog_enable, watchdog_long_timeout, stop_mode_permit}, 32'h1);
    bus(32'h0, 1'b1, 32'hFF, 32'h0);
    bus(32'h0, 1'b0, 32'h0, 32'h20);
    for (int n = 0; n < 8; n++) begin
      v = 32'h10 + 32'(n);
      bus(32'h4, 1'b1, v, 32'h0);
      bus(32'h4, 1'b0, 32'h0, v);
      repeat (4) @(posedge hclk);
      for (int k = 0; k < 2; k++) begin
        p = clock_out_port_pin;
        c = 32'h0;
        while (clock_out_port_pin === p && c < 32'h14) begin
          @(posedge hclk);
          c++;
        end
      end
      if (n == 0) chk({30'h0, clock_out_port_pin, clock_out_port_pin_oe_n}, 32'h0);
      else chk(c, 32'(n));
    end
    bus(32'h4, 1'b1, 32'h7, 32'h0);
    repeat (3) @(posedge hclk);
    chk({31'h0, clock_out_port_pin_oe_n}, 32'h1);
    rst_defaults();
    bus(32'h0, 1'b1, 32'hC0, 32'h0);
    bus(32'h0, 1'b1, 32'h20, 32'h0);
    bus(32'h0, 1'b0, 32'h0, 32'hC0);
    chk({29'h0, watchdog_enable, watchdog_long_timeout, stop_mode_permit}, 32'h6);
    repeat (20) @(posedge hclk);
    end_of_test();
  end
endmodule : system_options_clkout_partnum_test
`default_nettype wire
